// *** rtl/timer_compare_output.sv ***
// Eight-bit timer with normal and clear-on-match modes and compare output.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module timer_compare_output (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Interrupt service acknowledges
	input wire logic ovf_int_ack,
	input wire logic cmp_int_ack,
	// Flag levels toward the interrupt controller
	output logic ovf_flag_out,
	output logic cmp_flag_out,
	// Compare output pin
	output logic pin_out,
	output logic pin_oe
);
	typedef enum logic [1:0] {
		WAVE_IS_NORMAL = 2'h0,
		WAVE_IS_FAST = 2'h1,
		WAVE_IS_CLEAR = 2'h3,
		WAVE_IS_PHASE = 2'h2
	} wave_t;

	tick_if tk ();

	logic [7:0] ctrl_reg;
	logic [7:0] counter_value_reg;
	logic [7:0] compare_value_reg;
	logic overflow_flag_reg;
	logic compare_flag_reg;
	logic compare_output_state_reg;
	logic port_data_reg;
	logic output_pin_direction_bit_reg;
	logic match_block_reg;
	logic match_pending_reg;
	logic [7:0] reg_rdata_reg;
	logic pin_out_reg;
	logic pin_oe_reg;

	logic [1:0] compare_output_mode_field;
	logic [1:0] waveform_mode_field;
	wave_t wave_mode;
	logic timer_tick;
	logic non_pwm;
	logic wr_ctrl;
	logic wr_count;
	logic wr_compare;
	logic wr_status;
	logic wr_port;
	logic force_compare_strobe;
	logic match_raw;
	logic match_live;
	logic at_top;
	logic [7:0] counter_value_next;
	logic compare_output_state_next;
	logic apply_action;

	// Applies the non-PWM compare output action to a current state.
	function automatic logic com_action(input logic [1:0] mode,
			input logic cur);
		unique case (mode)
			tc_pkg::COM_NONE: com_action = cur;
			tc_pkg::COM_TOGGLE: com_action = ~cur;
			tc_pkg::COM_CLEAR: com_action = 1'b0;
			tc_pkg::COM_SET: com_action = 1'b1;
		endcase
	endfunction

	function automatic logic addr_write(input logic [2:0] a,
			input logic [2:0] target, input logic wr);
		addr_write = wr && (a == target);
	endfunction

	timer_prescaler u_prescaler (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tk(tk.src)
	);

	assign tk.clk_sel = ctrl_reg[tc_pkg::CTRL_CLK_SEL_LSB +: 3];
	assign timer_tick = tk.tick;
	// Compare output mode is read straight from the control register.
	assign compare_output_mode_field =
		ctrl_reg[tc_pkg::CTRL_COM_LSB +: 2];
	assign waveform_mode_field = ctrl_reg[tc_pkg::CTRL_WAVE_LSB +: 2];

	always_comb begin
		unique case (waveform_mode_field)
			tc_pkg::WAVE_NORMAL: wave_mode = WAVE_IS_NORMAL;
			tc_pkg::WAVE_FAST_PWM: wave_mode = WAVE_IS_FAST;
			tc_pkg::WAVE_CLEAR_MATCH: wave_mode = WAVE_IS_CLEAR;
			tc_pkg::WAVE_PHASE_PWM: wave_mode = WAVE_IS_PHASE;
		endcase
	end

	assign non_pwm = (wave_mode == WAVE_IS_NORMAL) ||
		(wave_mode == WAVE_IS_CLEAR);

	assign wr_ctrl = addr_write(reg_addr, tc_pkg::ADDR_CTRL, reg_wr);
	assign wr_count = addr_write(reg_addr, tc_pkg::ADDR_COUNT, reg_wr);
	assign wr_compare = addr_write(reg_addr, tc_pkg::ADDR_COMPARE, reg_wr);
	assign wr_status = addr_write(reg_addr, tc_pkg::ADDR_STATUS, reg_wr);
	assign wr_port = addr_write(reg_addr, tc_pkg::ADDR_PORT, reg_wr);
	assign force_compare_strobe = wr_ctrl &&
		reg_wdata[tc_pkg::CTRL_FORCE_BIT];

	// The compare register is unbuffered in both non-PWM modes.
	assign match_raw = (counter_value_reg == compare_value_reg);
	assign match_live = match_raw && !match_block_reg;
	assign at_top = match_live && (wave_mode == WAVE_IS_CLEAR);

	// Counting follows the tick and count writes; clear-on-match mode also restarts at a match.
	always_comb begin
		counter_value_next = counter_value_reg;
		if (wr_count) begin
			counter_value_next = reg_wdata;
		end else if (timer_tick) begin
			if (at_top) begin
				counter_value_next = tc_pkg::COUNT_BOTTOM;
			end else begin
				counter_value_next = counter_value_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			counter_value_reg <= tc_pkg::COUNT_RESET;
		end else begin
			counter_value_reg <= counter_value_next;
		end
	end

	// A count write holds a block that lasts until the next timer clock ends.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			match_block_reg <= 1'b0;
		end else if (wr_count) begin
			match_block_reg <= 1'b1;
		end else if (timer_tick) begin
			match_block_reg <= 1'b0;
		end
	end

	// The flag rises on the timer clock after the one that saw the match.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			match_pending_reg <= 1'b0;
		end else if (timer_tick) begin
			match_pending_reg <= match_live && non_pwm;
		end
	end

	// Set wins over a clear in the same cycle.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			compare_flag_reg <= 1'b0;
		end else if (timer_tick && match_pending_reg) begin
			compare_flag_reg <= 1'b1;
		end else if (cmp_int_ack ||
				(wr_status && reg_wdata[tc_pkg::STAT_CMP_BIT])) begin
			compare_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			overflow_flag_reg <= 1'b0;
		end else if (timer_tick && !wr_count && non_pwm &&
				counter_value_reg == tc_pkg::COUNT_MAX) begin
			overflow_flag_reg <= 1'b1;
		end else if (ovf_int_ack ||
				(wr_status && reg_wdata[tc_pkg::STAT_OVF_BIT])) begin
			overflow_flag_reg <= 1'b0;
		end
	end

	// A forced compare changes only the state flop, never flag or counter.
	assign apply_action = non_pwm &&
		(force_compare_strobe || (timer_tick && match_live));

	always_comb begin
		compare_output_state_next = compare_output_state_reg;
		if (apply_action) begin
			compare_output_state_next = com_action(
				force_compare_strobe ?
				reg_wdata[tc_pkg::CTRL_COM_LSB +: 2] :
				compare_output_mode_field,
				compare_output_state_reg);
		end
	end

	// The state flop lives apart from the pin so it can be preset.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			compare_output_state_reg <= 1'b0;
		end else begin
			compare_output_state_reg <= compare_output_state_next;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= tc_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			// The force bit is a strobe and always reads back zero.
			ctrl_reg <= {1'b0, reg_wdata[6:0]};
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			compare_value_reg <= tc_pkg::COMPARE_RESET;
		end else if (wr_compare) begin
			compare_value_reg <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_data_reg <= 1'b0;
			output_pin_direction_bit_reg <= 1'b0;
		end else if (wr_port) begin
			port_data_reg <= reg_wdata[tc_pkg::PORT_DATA_BIT];
			output_pin_direction_bit_reg <= reg_wdata[tc_pkg::PORT_DIR_BIT];
		end
	end

	// Pin gating reads the state flop, so the pin lags the flop by one edge,
	// and only the output mode decides the source.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_out_reg <= 1'b0;
			pin_oe_reg <= 1'b0;
		end else begin
			pin_out_reg <= (compare_output_mode_field != tc_pkg::COM_NONE) ?
				compare_output_state_reg : port_data_reg;
			pin_oe_reg <= output_pin_direction_bit_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				tc_pkg::ADDR_CTRL: reg_rdata_reg <= ctrl_reg;
				tc_pkg::ADDR_COUNT: reg_rdata_reg <= counter_value_reg;
				tc_pkg::ADDR_COMPARE: reg_rdata_reg <= compare_value_reg;
				tc_pkg::ADDR_STATUS: reg_rdata_reg <= {5'h00,
					compare_output_state_reg, compare_flag_reg,
					overflow_flag_reg};
				tc_pkg::ADDR_PORT: reg_rdata_reg <= {6'h00,
					output_pin_direction_bit_reg, port_data_reg};
				default: reg_rdata_reg <= 8'h00;
			endcase
		end else begin
			reg_rdata_reg <= 8'h00;
		end
	end

	assign reg_rdata = reg_rdata_reg;
	assign ovf_flag_out = overflow_flag_reg;
	assign cmp_flag_out = compare_flag_reg;
	assign pin_out = pin_out_reg;
	assign pin_oe = pin_oe_reg;
endmodule // timer_compare_output

// *** common/tc_pkg.sv ***
// Constants shared by the compare-output timer block.
package tc_pkg;

	// Register indices on the plain register port.
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_COUNT = 3'h1;
	localparam logic [2:0] ADDR_COMPARE = 3'h2;
	localparam logic [2:0] ADDR_STATUS = 3'h3;
	localparam logic [2:0] ADDR_PORT = 3'h4;

	// Control register fields.
	localparam int CTRL_CLK_SEL_LSB = 0;
	localparam int CTRL_WAVE_LSB = 3;
	localparam int CTRL_COM_LSB = 5;
	localparam int CTRL_FORCE_BIT = 7;

	// Status register fields; the two flags are write one to clear.
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_CMP_BIT = 1;
	localparam int STAT_OCS_BIT = 2;

	// Port register fields.
	localparam int PORT_DATA_BIT = 0;
	localparam int PORT_DIR_BIT = 1;

	// Reset values.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;

	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;

	// Waveform modes.
	localparam logic [1:0] WAVE_NORMAL = 2'h0;
	localparam logic [1:0] WAVE_FAST_PWM = 2'h1;
	localparam logic [1:0] WAVE_CLEAR_MATCH = 2'h2;
	localparam logic [1:0] WAVE_PHASE_PWM = 2'h3;

	// Compare output actions in the non-PWM modes.
	localparam logic [1:0] COM_NONE = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	// Prescaler selections.
	localparam logic [2:0] CLK_STOP = 3'h0;
	localparam logic [2:0] CLK_DIV1 = 3'h1;
	localparam logic [2:0] CLK_DIV8 = 3'h2;
	localparam logic [2:0] CLK_DIV32 = 3'h3;
	localparam logic [2:0] CLK_DIV64 = 3'h4;
	localparam logic [2:0] CLK_DIV128 = 3'h5;
	localparam logic [2:0] CLK_DIV256 = 3'h6;
	localparam logic [2:0] CLK_DIV1024 = 3'h7;
	localparam int PRESCALE_WIDTH = 10;

endpackage

// *** common/tick_if.sv ***
// Timer tick path between the prescaler and the timer core.
`timescale 1ns/1ps
interface tick_if;
	logic [2:0] clk_sel;
	logic tick;
	modport src (input clk_sel, output tick);
	modport dst (output clk_sel, input tick);
endinterface : tick_if

// *** rtl/timer_prescaler.sv ***
// Prescaler that makes the one-cycle timer clock enable.
`timescale 1ns/1ps
module timer_prescaler (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Tick path
	tick_if.src tk
);
	logic [tc_pkg::PRESCALE_WIDTH-1:0] div_reg;
	logic tick_next;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= '0;
		end else if (tk.clk_sel == tc_pkg::CLK_STOP) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 10'h001;
		end
	end

	// Divisors 1, 8, 32, 64, 128, 256 and 1024 as all-ones low bits.
	always_comb begin
		unique case (tk.clk_sel)
			tc_pkg::CLK_STOP: tick_next = 1'b0;
			tc_pkg::CLK_DIV1: tick_next = 1'b1;
			tc_pkg::CLK_DIV8: tick_next = &div_reg[2:0];
			tc_pkg::CLK_DIV32: tick_next = &div_reg[4:0];
			tc_pkg::CLK_DIV64: tick_next = &div_reg[5:0];
			tc_pkg::CLK_DIV128: tick_next = &div_reg[6:0];
			tc_pkg::CLK_DIV256: tick_next = &div_reg[7:0];
			tc_pkg::CLK_DIV1024: tick_next = &div_reg[9:0];
		endcase
	end

	assign tk.tick = tick_next;
endmodule // timer_prescaler

// *** test/pin_load.sv ***
// External load on the compare output pin.
`timescale 1ns/1ps
module pin_load (
	// Pin as driven by the block
	input wire logic pin_out,
	input wire logic pin_oe,
	// Level seen on the board
	output logic pin_level
);
	// A pull-up holds the line high while the pin is an input.
	assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule // pin_load

// *** test/timer_compare_output_chk.sv ***
// Port-level assertions for the compare-output timer.
`timescale 1ns/1ps
module timer_compare_output_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Flags and acknowledges
	input wire logic ovf_int_ack,
	input wire logic cmp_int_ack,
	input wire logic ovf_flag_out,
	input wire logic cmp_flag_out,
	// Pin
	input wire logic pin_out,
	input wire logic pin_oe
);
	logic [1:0] com_reg;
	logic [2:0] sel_reg;
	logic port_reg;
	logic st_wr;
	assign st_wr = reg_wr && reg_addr == tc_pkg::ADDR_STATUS;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			com_reg <= 2'h0;
			sel_reg <= 3'h0;
		end else if (reg_wr && reg_addr == tc_pkg::ADDR_CTRL) begin
			com_reg <= reg_wdata[6:5];
			sel_reg <= reg_wdata[2:0];
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_reg <= 1'b0;
		end else if (reg_wr && reg_addr == tc_pkg::ADDR_PORT) begin
			port_reg <= reg_wdata[tc_pkg::PORT_DATA_BIT];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	chk_unmapped_zero: assert property (
		reg_rd && reg_addr > tc_pkg::ADDR_PORT |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_force_reads0: assert property (
		reg_rd && reg_addr == tc_pkg::ADDR_CTRL |=> !reg_rdata[7])
		else $error("force strobe read back");
	chk_dir_follow: assert property (
		reg_wr && reg_addr == tc_pkg::ADDR_PORT |->
		##2 pin_oe == $past(reg_wdata[tc_pkg::PORT_DIR_BIT], 2))
		else $error("pin enable not from direction");
	chk_port_pass: assert property (
		$past(com_reg) == tc_pkg::COM_NONE |-> pin_out == $past(port_reg))
		else $error("port data not on pin");
	chk_ovf_hold: assert property (
		$fell(ovf_flag_out) |-> $past(ovf_int_ack || st_wr && reg_wdata[0])
		|| $past(ovf_int_ack || st_wr && reg_wdata[0], 2))
		else $error("overflow flag lost");
	chk_cmp_hold: assert property (
		$fell(cmp_flag_out) |-> $past(cmp_int_ack || st_wr && reg_wdata[1])
		|| $past(cmp_int_ack || st_wr && reg_wdata[1], 2))
		else $error("compare flag lost");
	chk_ack_clears: assert property (
		cmp_int_ack && sel_reg == 3'h0 && $past(sel_reg, 3) == 3'h0 |->
		##[1:2] !cmp_flag_out)
		else $error("compare flag not serviced");
	cover property ($rose(ovf_flag_out));
	cover property ($rose(cmp_flag_out));
	cover property (pin_oe && $changed(pin_out));
endmodule // timer_compare_output_chk

bind timer_compare_output timer_compare_output_chk u_timer_compare_output_chk (
	.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .ovf_int_ack(ovf_int_ack),
	.cmp_int_ack(cmp_int_ack), .ovf_flag_out(ovf_flag_out),
	.cmp_flag_out(cmp_flag_out), .pin_out(pin_out), .pin_oe(pin_oe));

// *** test/timer_compare_output_ctc_normal_tb.sv ***
// Self-checking bench for the compare-output timer.
`timescale 1ns/1ps
module timer_compare_output_ctc_normal_tb;
	logic core_clk, rst_b, reg_wr, reg_rd, ovf_int_ack, cmp_int_ack;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rdv;
	logic ovf_flag_out, cmp_flag_out, pin_out, pin_oe, pin_level, lvl;
	logic [1:0] coms [4];
	logic [3:0] sts;
	int mismatches, n_checks, k;
	timer_compare_output u_timer_compare_output (.core_clk(core_clk),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ovf_int_ack(ovf_int_ack), .cmp_int_ack(cmp_int_ack),
		.ovf_flag_out(ovf_flag_out), .cmp_flag_out(cmp_flag_out),
		.pin_out(pin_out), .pin_oe(pin_oe));
	pin_load u_pin_load (.pin_out(pin_out), .pin_oe(pin_oe),
		.pin_level(pin_level));
	task automatic chk(input string what, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
	endtask
	// Flags are only serviced with the timer stopped, so no set can race.
	task automatic ack();
		repeat (4) @(posedge core_clk);
		ovf_int_ack <= 1'b1;
		cmp_int_ack <= 1'b1;
		@(posedge core_clk);
		ovf_int_ack <= 1'b0;
		cmp_int_ack <= 1'b0;
	endtask
	function automatic logic [7:0] ctl(input logic [2:0] sel,
		input logic [1:0] wave, com, input logic frc);
		return {frc, com, wave, sel};
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#1_000_000;
		mismatches++;
		give_verdict();
	end
	initial begin
		{rst_b, reg_wr, reg_rd, ovf_int_ack, cmp_int_ack} = 5'h00;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		coms = '{tc_pkg::COM_SET, tc_pkg::COM_CLEAR, tc_pkg::COM_TOGGLE,
			tc_pkg::COM_NONE};
		sts = 4'b1101;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0]);
			chk("reset value", rdv, 8'h00);
		end
		wr(3'h5, 8'h5a);
		rd(3'h5);
		chk("unmapped", rdv, 8'h00);
		wr(tc_pkg::ADDR_COUNT, 8'h33);
		for (int i = 0; i < 4; i++) begin
			wr(tc_pkg::ADDR_CTRL, ctl(tc_pkg::CLK_STOP, tc_pkg::WAVE_NORMAL,
				coms[i], 1'b1));
			rd(tc_pkg::ADDR_STATUS);
			chk("state", rdv, {5'h0, sts[i], 2'h0});
			chk("pin", {pin_out, pin_level}, {sts[i] && coms[i], 1'b1});
		end
		rd(tc_pkg::ADDR_COUNT);
		chk("count", rdv, 8'h33);
		rd(tc_pkg::ADDR_CTRL);
		chk("control", rdv, 8'h00);
		wr(tc_pkg::ADDR_PORT, 8'h02);
		step();
		step();
		chk("pin enable", {pin_oe, pin_level}, 8'h02);
		wr(tc_pkg::ADDR_CTRL, ctl(tc_pkg::CLK_STOP, tc_pkg::WAVE_FAST_PWM,
			tc_pkg::COM_TOGGLE, 1'b0));
		step();
		step();
		chk("override", {7'h0, pin_level}, 8'h01);
		wr(tc_pkg::ADDR_COMPARE, 8'h80);
		wr(tc_pkg::ADDR_COUNT, 8'hfa);
		wr(tc_pkg::ADDR_CTRL, 8'h01);
		for (k = 0; k < 40 && ovf_flag_out !== 1'b1; k++) step();
		chk("overflow", {7'h0, ovf_flag_out}, 8'h01);
		wr(tc_pkg::ADDR_CTRL, 8'h00);
		rd(tc_pkg::ADDR_COUNT);
		chk("wrap", {7'h0, rdv < 8'h20}, 8'h01);
		ack();
		rd(tc_pkg::ADDR_STATUS);
		chk("serviced", rdv, 8'h04);
		wr(tc_pkg::ADDR_COUNT, 8'h00);
		wr(tc_pkg::ADDR_COMPARE, 8'h03);
		wr(tc_pkg::ADDR_CTRL, ctl(tc_pkg::CLK_DIV1,
			tc_pkg::WAVE_CLEAR_MATCH, tc_pkg::COM_TOGGLE, 1'b0));
		step();
		for (int j = 0; j < 3; j++) begin
			lvl = pin_out;
			for (k = 0; k < 20 && pin_out === lvl; k++) step();
			if (j > 0) chk("period", k[7:0], 8'h04);
		end
		chk("compare flag", {7'h0, cmp_flag_out}, 8'h01);
		wr(tc_pkg::ADDR_CTRL, 8'h00);
		rd(tc_pkg::ADDR_COUNT);
		chk("top", {7'h0, rdv <= 8'h03}, 8'h01);
		ack();
		wr(tc_pkg::ADDR_COUNT, 8'h50);
		wr(tc_pkg::ADDR_COMPARE, 8'h10);
		wr(tc_pkg::ADDR_CTRL, 8'h11);
		for (k = 0; k < 300 && ovf_flag_out !== 1'b1; k++) step();
		chk("late", {ovf_flag_out, cmp_flag_out}, 8'h02);
		wr(tc_pkg::ADDR_CTRL, 8'h00);
		ack();
		wr(tc_pkg::ADDR_COMPARE, 8'h05);
		wr(tc_pkg::ADDR_COUNT, 8'h05);
		wr(tc_pkg::ADDR_CTRL, 8'h11);
		repeat (20) step();
		chk("blocked", {7'h0, cmp_flag_out}, 8'h00);
		wr(tc_pkg::ADDR_COUNT, 8'h40);
		wr(tc_pkg::ADDR_CTRL, 8'h00);
		rd(tc_pkg::ADDR_COUNT);
		chk("count write", {rdv >= 8'h40, rdv < 8'h48}, 8'h03);
		give_verdict();
	end
endmodule // timer_compare_output_ctc_normal_tb
